/* File: hw/mcu_core_pkg.sv */
// Constants, encodings and carrier types shared by the program-flow core.
package mcu_core_pkg;

  localparam int PC_W    = 10;
  localparam int DATA_W  = 8;
  localparam int INSTR_W = 14;
  localparam int SP_W    = 2;

  // Clock and timing figures.
  localparam int CLK_SYS_MHZ      = 200;
  localparam int PHASES_PER_CYCLE = 4;

  // Reset and vector values.
  localparam logic [PC_W-1:0]   PC_RESET   = 10'h000;
  localparam logic [PC_W-1:0]   INT_VECTOR = 10'h004;
  localparam logic [2:0]        STACK_DEPTH = 3'h4;
  localparam logic [2:0]        LEVEL_RESET = 3'h0;
  localparam logic [SP_W-1:0]   WP_RESET    = 2'h0;
  localparam logic [INSTR_W-1:0] INSTR_NOP  = 14'h0000;

  // Register port byte offsets.
  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_STATE = 8'h04;
  localparam logic [7:0] REG_PCL   = 8'h08;
  localparam logic [7:0] REG_PCH   = 8'h0C;
  localparam logic [7:0] REG_FLAGS = 8'h10;

  // Control register fields and reset value.
  localparam int CTRL_RUN   = 0;
  localparam int CTRL_FAST  = 1;
  localparam int CTRL_INTEN = 2;
  localparam logic [2:0] CTRL_RESET = 3'h3;

  // Core state register fields.
  localparam int STATE_PHASE_LSB = 0;
  localparam int STATE_LEVEL_LSB = 2;
  localparam int STATE_INTPEND   = 5;
  localparam int STATE_INTMASTER = 6;
  localparam int STATE_DUMMY     = 7;

  // Arithmetic flag positions and reset value.
  localparam int ST_C  = 0;
  localparam int ST_AC = 1;
  localparam int ST_Z  = 2;
  localparam int ST_OV = 3;
  localparam logic [3:0] FLAGS_RESET = 4'h0;

  // Data-space addresses that the core itself answers.
  localparam logic [7:0] DATA_PCL_ADDR   = 8'h06;
  localparam logic [7:0] DATA_FLAGS_ADDR = 8'h0A;

  // Instruction layout: control transfers carry 2'b11 in the top bits.
  localparam int OPC_MSB   = 13;
  localparam int OPC_LSB   = 9;
  localparam int DEST_BIT  = 8;
  localparam int CALL_BIT  = 11;

  typedef enum logic [1:0] {
    PH_FETCH = 2'b00,
    PH_DEC   = 2'b01,
    PH_EXA   = 2'b11,
    PH_EXB   = 2'b10
  } phase_t;

  typedef enum logic [4:0] {
    OP_NOP, OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_DAA, OP_AND, OP_OR,
    OP_XOR, OP_CPL, OP_RR, OP_RRC, OP_RL, OP_RLC, OP_INC, OP_DEC,
    OP_SZ, OP_SNZ, OP_SIZ, OP_SDZ, OP_RET, OP_INTERRUPT_EXIT_INSTR, OP_LDA, OP_STA
  } opcode_t;

  typedef struct packed {
    logic [PC_W-1:0] addr;
    logic            rd;
  } progReq_t;

  typedef struct packed {
    logic [DATA_W-1:0] addr;
    logic              rd;
    logic              wr;
    logic [DATA_W-1:0] wdata;
  } dataReq_t;

endpackage

/* File: hw/mcu_core_program_flow.sv */
// Program-flow, pipeline and ALU control of the 8-bit core.
//
// Notes on behaviour
// RULE_01 - Four gray-coded phases make one instruction cycle.
// RULE_02 - Phases step on fast or slow oscillator tick.
// RULE_03 - Fetch phase increments counter and fetches instruction.
// RULE_04 - Phases two to four decode and execute.
// RULE_05 - Next fetch overlaps current execute.
// RULE_06 - Jumps and calls take two instruction cycles.
// RULE_07 - Counter advances by one unless control transfers.
// RULE_08 - Taken skip discards prefetched instruction, dummy cycle.
// RULE_09 - Ten-bit counter, only low byte software visible.
// RULE_10 - Low-byte write jumps in page, inserts dummy.
// RULE_11 - Transfers load the target straight into counter.
// RULE_12 - Reset loads counter with address zero.
// RULE_13 - Four-level hidden return stack of counter values.
// RULE_14 - Call and interrupt push; returns pop.
// RULE_15 - Reset leaves stack pointer at top.
// RULE_16 - Full stack defers interrupt until a return.
// RULE_17 - Call on full stack overwrites oldest entry.
// RULE_18 - 8-bit ALU through accumulator to chosen destination.
// RULE_19 - ALU updates carry, borrow and other flags.
// RULE_20 - Add, subtract with carry forms, decimal adjust.
// RULE_21 - Logic, complement, rotates, increment and decrement.
// RULE_22 - Jump, call, returns and four skip instructions.
// RULE_23 - Dummy cycle flushes prefetch with no side effects.
`timescale 1ns/100ps
`default_nettype none
module mcu_core_program_flow (
  input  wire logic                          clk_sys,     // 200 MHz clock.
  input  wire logic                          reset,       // Sync, high.
  input  wire logic                          fastOscTick, // Fast source.
  input  wire logic                          slowOscTick, // Slow source.
  input  wire logic                          intReq,      // Int request.
  output mcu_core_pkg::progReq_t             prog,        // Fetch request.
  input  wire logic [13:0]                   progData,    // Fetched word.
  output mcu_core_pkg::dataReq_t             data,        // Data access.
  input  wire logic [7:0]                    dataRdData,  // Data answer.
  input  wire logic [7:0]                    regAddr,     // Reg address.
  input  wire logic [7:0]                    regWrData,   // Reg write data.
  input  wire logic                          regWr,       // Reg write.
  input  wire logic                          regRd,       // Reg read.
  output logic      [7:0]                    regRdData    // Reg read data.
);
  import mcu_core_pkg::*;

  // Adds with carry in; returns {ov, ac, c, sum}.
  function automatic logic [10:0] addCore(input logic [7:0] a,
                                          input logic [7:0] b,
                                          input logic       cin);
    logic [8:0] full;
    logic [4:0] half;
    logic       ov;
    full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    half = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    ov   = (a[7] == b[7]) && (full[7] != a[7]);
    return {ov, half[4], full[8], full[7:0]};
  endfunction

  phase_t               phase;
  logic [2:0]           ctrl;
  logic [PC_W-1:0]      pc;
  logic [PC_W-1:0]      execAddr;
  logic [INSTR_W-1:0]   execInstr;
  logic [INSTR_W-1:0]   prefetch;
  logic                 dummy;
  logic [7:0]           acc;
  logic [3:0]           flags;
  logic [7:0]           memVal;
  logic [7:0]           operand;
  logic                 progPending;
  logic                 dataPending;
  logic                 intPending;
  logic                 intMaster;
  logic                 hostPclPend;
  logic [7:0]           hostPclVal;
  logic [SP_W-1:0]      wp;
  logic [2:0]           level;
  logic [PC_W-1:0]      stackTop;

  logic                 step;
  logic                 commit;
  logic                 isXfer;
  opcode_t              op;
  logic                 toMem;
  logic [7:0]           mAddr;
  logic [7:0]           aluRes;
  logic [3:0]           next_flags;
  logic                 writesDest;
  logic                 skip;
  logic                 doPop;
  logic                 isReti;
  logic                 needsRead;
  logic [10:0]          sumBits;
  logic [8:0]           daaSum;
  logic                 writeAcc;
  logic                 writeMem;
  logic                 pclWrite;
  logic                 flagsWrite;
  logic                 redirect;
  logic                 intAck;
  logic                 push;
  logic [PC_W-1:0]      next_pc;

  // The phase sequencer only moves on a tick of the selected oscillator,
  // so the slow source stretches every phase without a second clock.
  assign step = ctrl[CTRL_RUN] &
                (ctrl[CTRL_FAST] ? fastOscTick : slowOscTick); // RULE_02

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      phase <= PH_FETCH;
    end else if (step) begin
      case (phase) // RULE_01
        PH_FETCH: phase <= PH_DEC;
        PH_DEC:   phase <= PH_EXA;
        PH_EXA:   phase <= PH_EXB;
        PH_EXB:   phase <= PH_FETCH;
        default:  phase <= PH_FETCH;
      endcase
    end
  end

  assign commit = step && (phase == PH_EXB);

  // Instruction field decode.
  assign isXfer = (execInstr[13:12] == 2'b11);
  assign op     = isXfer ? OP_NOP : opcode_t'(execInstr[OPC_MSB:OPC_LSB]);
  assign toMem  = execInstr[DEST_BIT];
  assign mAddr  = execInstr[7:0];

  // The core owns the low counter byte and the flags in data space.
  always_comb begin
    if (mAddr == DATA_PCL_ADDR) begin
      operand = execAddr[7:0]; // RULE_09
    end else if (mAddr == DATA_FLAGS_ADDR) begin
      operand = {4'h0, flags};
    end else if (dataPending) begin
      operand = dataRdData;
    end else begin
      operand = memVal;
    end
  end

  // ALU: result, flag update and flow decisions for the executing word.
  always_comb begin
    aluRes     = operand;
    next_flags = flags;
    writesDest = 1'b0;
    skip       = 1'b0;
    doPop      = 1'b0;
    isReti     = 1'b0;
    needsRead  = 1'b1;
    sumBits    = 11'h000;
    daaSum     = 9'h000;
    case (op)
      OP_ADD, OP_ADC, OP_SUB, OP_SBC: begin // RULE_20
        if (op == OP_ADD || op == OP_ADC) begin
          sumBits = addCore(acc, operand, (op == OP_ADC) & flags[ST_C]);
        end else begin
          sumBits = addCore(acc, ~operand,
                            (op == OP_SUB) | flags[ST_C]);
        end
        aluRes     = sumBits[7:0];
        next_flags = {sumBits[10], (sumBits[7:0] == 8'h00),
                      sumBits[9], sumBits[8]}; // RULE_19
        writesDest = 1'b1;
      end
      OP_DAA: begin
        daaSum = {1'b0, acc};
        if (acc[3:0] > 4'h9 || flags[ST_AC]) begin
          daaSum = daaSum + 9'h006;
        end
        if (acc > 8'h99 || flags[ST_C]) begin
          daaSum = daaSum + 9'h060;
        end
        aluRes            = daaSum[7:0];
        next_flags[ST_C]  = daaSum[8] | flags[ST_C];
        writesDest        = 1'b1;
        needsRead         = toMem;
      end
      OP_AND, OP_OR, OP_XOR, OP_CPL, OP_INC, OP_DEC: begin // RULE_21
        case (op)
          OP_AND:  aluRes = acc & operand;
          OP_OR:   aluRes = acc | operand;
          OP_XOR:  aluRes = acc ^ operand;
          OP_INC:  aluRes = operand + 8'h01;
          OP_DEC:  aluRes = operand - 8'h01;
          default: aluRes = ~operand;
        endcase
        next_flags[ST_Z] = (aluRes == 8'h00);
        writesDest       = 1'b1;
      end
      OP_RR:  begin aluRes = {operand[0], operand[7:1]}; writesDest = 1'b1; end
      OP_RL:  begin aluRes = {operand[6:0], operand[7]}; writesDest = 1'b1; end
      OP_RRC: begin
        aluRes           = {flags[ST_C], operand[7:1]};
        next_flags[ST_C] = operand[0];
        writesDest       = 1'b1;
      end
      OP_RLC: begin
        aluRes           = {operand[6:0], flags[ST_C]};
        next_flags[ST_C] = operand[7];
        writesDest       = 1'b1;
      end
      OP_SZ, OP_SNZ: begin // RULE_22
        skip       = (op == OP_SZ) ? (operand == 8'h00) : (operand != 8'h00);
        writesDest = !toMem;
      end
      OP_SIZ, OP_SDZ: begin
        aluRes     = (op == OP_SIZ) ? operand + 8'h01 : operand - 8'h01;
        skip       = (aluRes == 8'h00);
        writesDest = 1'b1;
      end
      OP_RET, OP_INTERRUPT_EXIT_INSTR: begin
        doPop     = 1'b1;
        isReti    = (op == OP_INTERRUPT_EXIT_INSTR);
        needsRead = 1'b0;
      end
      OP_LDA: writesDest = 1'b1;
      OP_STA: begin
        aluRes     = acc;
        writesDest = 1'b1;
        needsRead  = 1'b0;
      end
      default: needsRead = 1'b0;
    endcase
  end

  // A flushed word never reaches any destination.
  assign writeAcc   = !dummy && writesDest && !toMem; // RULE_18 RULE_23
  assign writeMem   = !dummy && writesDest && toMem;
  assign pclWrite   = writeMem && (mAddr == DATA_PCL_ADDR); // RULE_10
  assign flagsWrite = writeMem && (mAddr == DATA_FLAGS_ADDR);
  assign redirect   = !dummy && (isXfer || doPop || pclWrite);

  // A full stack holds the acknowledge back; the request stays pending.
  assign intAck = commit && intPending && intMaster &&
                  (level != STACK_DEPTH) && !redirect; // RULE_16
  assign push   = commit && ((!dummy && isXfer && execInstr[CALL_BIT])
                             || intAck); // RULE_14

  always_comb begin
    if (!dummy && isXfer) begin
      next_pc = execInstr[PC_W-1:0]; // RULE_11
    end else if (!dummy && doPop) begin
      next_pc = stackTop; // RULE_14
    end else if (pclWrite) begin
      // The counter has already moved on and may sit in the next page.
      next_pc = {execAddr[9:8], aluRes}; // RULE_10
    end else if (intAck) begin
      next_pc = INT_VECTOR; // RULE_11
    end else begin
      next_pc = {pc[9:8], hostPclVal};
    end
  end

  // Program counter and fetch port.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pc       <= PC_RESET; // RULE_12
      prog     <= '0;
      execAddr <= PC_RESET;
    end else begin
      prog.rd <= 1'b0;
      if (step && phase == PH_FETCH) begin
        prog.addr <= pc; // RULE_03 RULE_05
        prog.rd   <= 1'b1;
        pc        <= pc + 10'h001; // RULE_07
      end else if (commit && (redirect || intAck || hostPclPend)) begin
        pc <= next_pc; // RULE_06
      end
      if (commit) begin
        execAddr <= prog.addr;
      end
    end
  end

  // Pipeline registers: the prefetched word becomes the executing word.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      progPending <= 1'b0;
      prefetch    <= INSTR_NOP;
      execInstr   <= INSTR_NOP;
      dummy       <= 1'b1;
    end else begin
      // Program memory answers in the cycle after the fetch strobe.
      progPending <= prog.rd;
      if (progPending) begin
        prefetch <= progData;
      end
      if (commit) begin
        execInstr <= prefetch; // RULE_04
        // The stale prefetch runs as a dummy after any change of flow.
        dummy <= redirect || intAck || hostPclPend ||
                 (!dummy && skip); // RULE_08 RULE_23
      end
    end
  end

  // Data port: read in the decode phase, write back at the last phase.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      data        <= '0;
      dataPending <= 1'b0;
      memVal      <= 8'h00;
    end else begin
      data.rd     <= 1'b0;
      data.wr     <= 1'b0;
      dataPending <= data.rd;
      if (dataPending) begin
        memVal <= dataRdData;
      end
      // Core-owned addresses are answered inside and never reach the port.
      if (step && phase == PH_DEC && !dummy && needsRead &&
          mAddr != DATA_PCL_ADDR && mAddr != DATA_FLAGS_ADDR) begin // RULE_04
        data.addr <= mAddr;
        data.rd   <= 1'b1;
      end else if (commit && writeMem && !pclWrite && !flagsWrite) begin
        data.addr  <= mAddr;
        data.wr    <= 1'b1;
        data.wdata <= aluRes; // RULE_18
      end
    end
  end

  // Accumulator and flags.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      acc   <= 8'h00;
      flags <= FLAGS_RESET;
    end else if (commit && !dummy) begin
      if (writeAcc) begin
        acc <= aluRes;
      end
      if (flagsWrite) begin
        flags <= aluRes[3:0];
      end else begin
        flags <= next_flags; // RULE_19
      end
    end
  end

  // Return stack: a ring, so a push on a full stack drops the oldest.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wp    <= WP_RESET; // RULE_15
      level <= LEVEL_RESET;
    end else if (push) begin
      wp <= wp + 2'h1; // RULE_17
      if (level != STACK_DEPTH) begin
        level <= level + 3'h1;
      end
    end else if (commit && !dummy && doPop) begin
      wp <= wp - 2'h1;
      if (level != LEVEL_RESET) begin
        level <= level - 3'h1;
      end
    end
  end

  stack_mem u_stack ( // RULE_13
    .clk_sys (clk_sys),
    .wrEn    (push),
    .wrAddr  (wp),
    .wrData  (prog.addr),
    .rdAddr  (wp - 2'h1),
    .rdData  (stackTop)
  );

  // Interrupt request flag; a new request wins over the acknowledge.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      intPending <= 1'b0;
      intMaster  <= 1'b1;
    end else begin
      if (intReq && ctrl[CTRL_INTEN]) begin
        intPending <= 1'b1; // RULE_16
      end else if (intAck) begin
        intPending <= 1'b0;
      end
      if (intAck) begin
        intMaster <= 1'b0;
      end else if (commit && !dummy && isReti) begin
        intMaster <= 1'b1;
      end
    end
  end

  // Register port writes. A low-byte write from the port is queued and
  // taken at the next cycle boundary with no other change of flow or interrupt acknowledge, like a program write.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctrl        <= CTRL_RESET;
      hostPclPend <= 1'b0;
      hostPclVal  <= 8'h00;
    end else begin
      if (regWr && regAddr == REG_CTRL) begin
        ctrl <= regWrData[2:0];
      end
      if (regWr && regAddr == REG_PCL) begin
        hostPclPend <= 1'b1; // RULE_10
        hostPclVal  <= regWrData;
      end else if (commit && !redirect && !intAck) begin
        hostPclPend <= 1'b0;
      end
    end
  end

  // Register port reads; unmapped offsets read as zero.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      regRdData <= 8'h00;
    end else if (regRd) begin
      case (regAddr)
        REG_CTRL:  regRdData <= {5'h00, ctrl};
        REG_STATE: regRdData <= {dummy, intMaster, intPending, level,
                                 phase};
        REG_PCL:   regRdData <= pc[7:0];
        REG_PCH:   regRdData <= {6'h00, pc[9:8]};
        REG_FLAGS: regRdData <= {4'h0, flags};
        default:   regRdData <= 8'h00;
      endcase
    end else begin
      regRdData <= 8'h00;
    end
  end

endmodule // mcu_core_program_flow
`default_nettype wire

/* File: hw/stack_mem.sv */
// Four-word return-address memory with a registered read port.
`timescale 1ns/100ps
`default_nettype none
module stack_mem (
  input  wire logic                           clk_sys, // System clock.
  input  wire logic                           wrEn,    // Push strobe.
  input  wire logic [mcu_core_pkg::SP_W-1:0]  wrAddr,  // Push slot.
  input  wire logic [mcu_core_pkg::PC_W-1:0]  wrData,  // Pushed address.
  input  wire logic [mcu_core_pkg::SP_W-1:0]  rdAddr,  // Top slot.
  output logic      [mcu_core_pkg::PC_W-1:0]  rdData   // Registered top.
);
  import mcu_core_pkg::*;

  logic [PC_W-1:0] slot [0:(1<<SP_W)-1];

  always_ff @(posedge clk_sys) begin
    if (wrEn) begin
      slot[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge clk_sys) begin
    rdData <= slot[rdAddr];
  end

endmodule // stack_mem
`default_nettype wire

/* File: verif/mcu_core_program_flow_checker.sv */
// Port assertions for the program-flow core, bound to its top module.
`timescale 1ns/100ps
`default_nettype none
module mcu_core_program_flow_checker (
  input wire logic                   clk_sys,   // System clock.
  input wire logic                   reset,     // Sync reset, high.
  input wire mcu_core_pkg::progReq_t prog,      // Fetch request.
  input wire mcu_core_pkg::dataReq_t data,      // Data access.
  input wire logic [7:0]             regAddr,   // Register address.
  input wire logic                   regRd,     // Register read.
  input wire logic [7:0]             regRdData  // Register read data.
);
  import mcu_core_pkg::*;
  logic fetchSeen; // Set by the first fetch after reset.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      fetchSeen <= 1'b0;
    end else if (prog.rd) begin
      fetchSeen <= 1'b1;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  sequence fetchGap;
    !prog.rd [*3];
  endsequence
  sequence firstFetch;
    ##[0:8] prog.rd;
  endsequence
  chk_fetch_spacing: assert property (
    prog.rd |=> fetchGap)
    else $error("Two fetches inside one instruction cycle.");
  chk_addr_hold: assert property (
    !prog.rd |-> $stable(prog.addr))
    else $error("Fetch address moved between fetches.");
  chk_first_fetch: assert property (
    prog.rd && !fetchSeen |-> prog.addr == PC_RESET)
    else $error("First fetch after reset not at address zero.");
  chk_fetch_soon: assert property (
    $fell(reset) |-> firstFetch)
    else $error("No fetch soon after reset release.");
  chk_idle_read: assert property (
    !regRd |=> regRdData == 8'h00)
    else $error("Read data present without a read strobe.");
  chk_upper_read: assert property (
    regRd && regAddr == 8'h0C |=> regRdData[7:2] == 6'h00)
    else $error("Upper counter read shows more than two bits.");
  chk_internal_addr: assert property (
    data.rd || data.wr |-> data.addr != 8'h06 && data.addr != 8'h0A)
    else $error("Core-owned address leaked onto the data port.");
  chk_data_pulse: assert property (
    data.wr |-> !data.rd ##1 !data.wr)
    else $error("Data write strobe overlaps or is not one cycle.");
endmodule // mcu_core_program_flow_checker
bind mcu_core_program_flow mcu_core_program_flow_checker
  i_mcu_core_program_flow_checker (
  .clk_sys(clk_sys), .reset(reset), .prog(prog), .data(data),
  .regAddr(regAddr), .regRd(regRd), .regRdData(regRdData));
`default_nettype wire

/* File: verif/mcu_mem_model.sv */
// Program and data memories that face the core's fetch and data ports.
`timescale 1ns/100ps
`default_nettype none
module mcu_mem_model (
  input  wire mcu_core_pkg::progReq_t prog,       // Fetch request.
  input  wire logic                   clk_sys,    // System clock.
  output logic [13:0]                 progData,   // Fetched word.
  input  wire mcu_core_pkg::dataReq_t data,       // Data access.
  output logic [7:0]                  dataRdData  // Data answer.
);
  import mcu_core_pkg::*;
  logic [INSTR_W-1:0] progMem [0:1023];
  logic [DATA_W-1:0]  dataMem [0:255];
  initial begin
    foreach (progMem[i]) progMem[i] = INSTR_NOP;
    foreach (dataMem[i]) dataMem[i] = 8'h00;
    progData = 14'h0000;
    dataRdData = 8'h00;
  end
  // Answers stand one cycle only; afterwards the bus toggles so that a
  // late sample by the core cannot match by chance.
  always @(posedge clk_sys) begin
    if (prog.rd === 1'b1) begin
      progData <= progMem[prog.addr];
    end else begin
      progData <= ~progData;
    end
  end
  always @(posedge clk_sys) begin
    if (data.rd === 1'b1) begin
      dataRdData <= dataMem[data.addr];
    end else begin
      dataRdData <= ~dataRdData;
    end
    if (data.wr === 1'b1) begin
      dataMem[data.addr] <= data.wdata;
    end
  end
endmodule // mcu_mem_model
`default_nettype wire

/* File: verif/tb_top.sv */
// Bench: a short program exercises fetch, branches, stack and registers.
`timescale 1ns/100ps
`default_nettype none
`define CHECK(nm, exp, got) \
  begin \
    compares++; \
    if ((got) !== (exp)) begin \
      fail_count++; \
      $display("MISMATCH %s expected %h seen %h", nm, exp, got); \
    end \
  end
module tb_top;
  import mcu_core_pkg::*;
  logic            clk_sys;     // System clock.
  logic            reset;       // Sync reset.
  logic            fastOscTick; // Fast step enable.
  logic            slowOscTick = 1'b0; // Slow step enable.
  logic            intReq;      // Interrupt request.
  progReq_t        prog;        // Fetch request.
  logic [13:0]     progData;    // Fetched word.
  dataReq_t        data;        // Data access.
  logic [7:0]      dataRdData;  // Data answer.
  logic [7:0]      regAddr;     // Register address.
  logic [7:0]      regWrData;   // Register write data.
  logic            regWr;       // Register write.
  logic            regRd;       // Register read.
  logic [7:0]      regRdData;   // Register read data.
  logic [1:0]      tickDiv = 2'h0; // Slow tick divider.
  logic            fetchHit [0:1023];
  logic [PC_W-1:0] fetchQ [$];
  logic [15:0]     wrQ [$];
  logic [7:0]      v;
  int              fail_count = 0;
  int              compares = 0;
  int              cycle = 0;
  int              lastFetch = 0;
  int              fetchGap = 0;
  logic [PC_W-1:0] expFetch [0:15] = '{10'h000, 10'h001, 10'h002, 10'h003,
    10'h004, 10'h005, 10'h040, 10'h041, 10'h042, 10'h005, 10'h006, 10'h007,
    10'h008, 10'h009, 10'h00A, 10'h109};
  logic [15:0]     expWr [0:3] = '{16'h3081, 16'h227E, 16'h3181, 16'h3300};

  mcu_core_program_flow i_mcu_core_program_flow (
    .clk_sys(clk_sys), .reset(reset), .fastOscTick(fastOscTick),
    .slowOscTick(slowOscTick), .intReq(intReq), .prog(prog),
    .progData(progData), .data(data), .dataRdData(dataRdData),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData));
  mcu_mem_model i_mcu_mem_model (
    .prog(prog), .clk_sys(clk_sys), .progData(progData), .data(data),
    .dataRdData(dataRdData));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // The slow source steps once every three system clocks.
  always @(posedge clk_sys) begin
    tickDiv <= (tickDiv == 2'h2) ? 2'h0 : tickDiv + 2'h1;
    slowOscTick <= (tickDiv == 2'h2);
  end
  always @(posedge clk_sys) begin
    cycle++;
    if (prog.rd === 1'b1) begin
      fetchQ.push_back(prog.addr);
      fetchHit[prog.addr] = 1'b1;
      fetchGap = cycle - lastFetch;
      lastFetch = cycle;
    end
    if (data.wr === 1'b1) begin
      wrQ.push_back({data.addr, data.wdata});
    end
  end

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic put(input logic [9:0] a, input logic [13:0] w);
    i_mcu_mem_model.progMem[a] = w;
  endtask
  task automatic regWrite(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask
  task automatic regRead(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 d = regRdData;
  endtask
  task automatic checkReg(input logic [7:0] a, input logic [7:0] e,
                          input string nm);
    logic [7:0] d;
    regRead(a, d);
    `CHECK(nm, e, d)
  endtask
  // Every wait is bounded; a wait that runs out ends the run at once.
  task automatic waitFetch(input logic [PC_W-1:0] a);
    int n = 0;
    while (fetchHit[a] !== 1'b1 && n < 4000) begin
      @(posedge clk_sys);
      n++;
    end
    `CHECK("fetch seen", 1'b1, fetchHit[a])
    if (fetchHit[a] !== 1'b1) begin
      report_and_stop();
    end
  endtask

  initial begin
    foreach (fetchHit[i]) fetchHit[i] = 1'b0;
    reset = 1'b1;
    fastOscTick = 1'b1;
    intReq = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    repeat (2) @(posedge clk_sys);
    put(10'h001, 14'h2C20);
    put(10'h002, 14'h0221);
    put(10'h003, 14'h2F30);
    put(10'h004, 14'h3840);
    put(10'h005, 14'h2F31);
    put(10'h006, 14'h2023);
    put(10'h007, 14'h2F32);
    put(10'h008, 14'h2F33);
    put(10'h009, 14'h3109);
    put(10'h040, 14'h1122);
    put(10'h041, 14'h2800);
    put(10'h150, 14'h2F34);
    put(10'h152, 14'h3151);
    i_mcu_mem_model.dataMem[8'h20] = 8'h35;
    i_mcu_mem_model.dataMem[8'h21] = 8'h4C;
    i_mcu_mem_model.dataMem[8'h22] = 8'hFF;
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    checkReg(8'h00, 8'h03, "control");
    regRead(8'h04, v);
    `CHECK("stack level", 3'h0, v[4:2])
    checkReg(8'h14, 8'h00, "unmapped");
    waitFetch(10'h109);
    foreach (expFetch[i]) `CHECK("fetch", expFetch[i], fetchQ[i])
    foreach (expWr[i]) `CHECK("write", expWr[i], wrQ[i])
    checkReg(8'h0C, 8'h01, "upper pc");
    regWrite(8'h0C, 8'h02);
    checkReg(8'h0C, 8'h01, "upper pc");
    regWrite(8'h08, 8'h50);
    waitFetch(10'h153);
    `CHECK("page jump", 16'h3400, wrQ[4])
    fetchHit[INT_VECTOR] = 1'b0;
    regWrite(8'h00, 8'h07);
    intReq <= 1'b1;
    waitFetch(INT_VECTOR);
    intReq <= 1'b0;
    regWrite(8'h00, 8'h01);
    fetchHit[10'h153] = 1'b0;
    waitFetch(10'h153);
    `CHECK("slow gap", 12, fetchGap)
    regRead(8'h04, v);
    `CHECK("stack level", 3'h1, v[4:2])
    checkReg(8'h10, 8'h0A, "flags");
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
